//--- include/atf_pkg.sv
// Constants, types and decode codes for the task file host port.
// Assumes one 200 MHz system clock and a synchronous active-high reset.
package atf_pkg;
  // System clock period in ns.
  localparam int unsigned CLK_PERIOD_NS = 5;
  // Widths and write buffer depth.
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned FIFO_DEPTH = 16;
  // Map select codes.
  localparam logic [1:0] MAP_MEMORY     = 2'h0;
  localparam logic [1:0] MAP_CONTIGUOUS = 2'h1;
  localparam logic [1:0] MAP_PRIMARY    = 2'h2;
  localparam logic [1:0] MAP_SECONDARY  = 2'h3;
  // Upper address fields A9..A4 for the I/O maps.
  localparam logic [5:0] PRI_TASK_BASE = 6'h1F;
  localparam logic [5:0] PRI_ALT_BASE  = 6'h3F;
  localparam logic [5:0] SEC_TASK_BASE = 6'h17;
  localparam logic [5:0] SEC_ALT_BASE  = 6'h37;
  // Address bit positions.
  localparam int unsigned A_HI_MSB = 9;
  localparam int unsigned A_HI_LSB = 4;
  localparam int unsigned A3_BIT   = 3;
  // Task file offsets selected by A2..A0.
  localparam logic [2:0] OFS_DATA      = 3'h0;
  localparam logic [2:0] OFS_ERR_FEAT  = 3'h1;
  localparam logic [2:0] OFS_SCOUNT    = 3'h2;
  localparam logic [2:0] OFS_SNUM      = 3'h3;
  localparam logic [2:0] OFS_CYL_LO    = 3'h4;
  localparam logic [2:0] OFS_CYL_HI    = 3'h5;
  localparam logic [2:0] OFS_DRV_HEAD  = 3'h6;
  localparam logic [2:0] OFS_STAT_CMD  = 3'h7;
  localparam logic [2:0] OFS_ALT_CTRL  = 3'h6;
  localparam logic [2:0] OFS_DRV_ADDR  = 3'h7;
  // Error cause bits; others read zero.
  localparam int unsigned ERR_BAD_BLOCK = 7;
  localparam int unsigned ERR_UNCORR    = 6;
  localparam int unsigned ERR_MISSING   = 4;
  localparam int unsigned ERR_ABORTED   = 2;
  localparam int unsigned ERR_GENERAL   = 0;
  // Busy flag position in the status byte.
  localparam int unsigned STAT_BUSY = 7;
  // Drive address byte fields.
  localparam int unsigned DH_DRV_BIT  = 4;
  localparam logic [1:0]  DRV_ADDR_TOP = 2'h3;
  // Reset values.
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  RST_DRV_HEAD = 8'hA0;
  // Sector count zero stands for this many sectors.
  localparam logic [8:0]  FULL_SECTOR_RUN = 9'h100;
  // Decoded register selects.
  typedef enum logic [3:0] {
    SEL_NONE = 4'h0,
    SEL_TASK = 4'h1,
    SEL_ALT  = 4'h2,
    SEL_DADR = 4'h3
  } atf_sel_t;
  // Host access state, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } atf_state_t;
endpackage

//--- logic/atf_fifo.sv
// Synchronous FIFO with a registered read word.
// Assumes both sides share one clock.
`timescale 1ns/10ps
`default_nettype none
module atf_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  // Filling side.
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side.
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } atf_fifo_st_t;

  atf_fifo_st_t st_q;
  atf_fifo_st_t st_d;
  logic         push;
  logic         pop;

  assign in_ready_o  = (st_q.count != CNT_FULL);
  assign out_valid_o = st_q.out_valid;
  assign out_data_o  = st_q.out_data;

  always_comb begin
    st_d = st_q;
    push = in_valid_i && (st_q.count != CNT_FULL);
    pop  = (st_q.count != '0) && (!st_q.out_valid || out_ready_i);
    if (out_ready_i && st_q.out_valid) begin
      st_d.out_valid = 1'b0;
    end
    if (push) begin
      st_d.mem[st_q.wr_ptr] = in_data_i;
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.out_data  = st_q.mem[st_q.rd_ptr];
      st_d.out_valid = 1'b1;
      st_d.rd_ptr    = st_q.rd_ptr + 1'b1;
    end
    st_d.count = st_q.count + CNT_W'(push) - CNT_W'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule
`default_nettype wire

//--- logic/atf_host_port.sv
// Host task file port: I/O decode, data port and parameter registers.
// Assumes async host pins; engine and configuration run on clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
// Contract
// RL1: Primary: 1F, A3 low; 3F at offsets 6 and 7.
// RL2: Secondary: 17, A3 low; 37 at offsets 6 and 7.
// RL3: Direct disk mode decodes by chip selects and A2..A0.
// RL4: Data port is 16-bit read/write, word or byte wide; in direct disk mode only byte accesses decode.
// RL5: Data port shares decode with error/feature.
// RL6: Error register is read-only; valid when not busy.
// RL7: Error bits 7,6,4,2,0 carry causes; 5,3,1 read zero.
// RL8: Refused commands set the aborted bit.
// RL9: Uncorrectable read errors set the uncorrectable bit.
// RL10: Unfound sector identifiers set the sector-missing bit.
// RL11: Feature is a write-only byte at the error location.
// RL12: Sector count zero means 256 sectors.
// RL13: A failed transfer leaves the remaining count.
// RL14: Sector number is the starting sector.
// RL15: Cylinder low is the low starting cylinder byte.
// RL16: Cylinder high is the high starting cylinder byte.
// RL17: Busy is status bit 7.
// RL18: In level interrupt I/O maps a status read negates the interrupt.
// RL19: Alternate status reads like status, interrupt untouched.
// RL20: Unmatched addresses and reserved writes are ignored.
module atf_host_port (
  // Clock and reset.
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Host pins, asynchronous.
  input  wire logic [10:0] addr_i,
  input  wire logic        attr_select_n_i,
  input  wire logic        chip_select_low_n_i,
  input  wire logic        chip_select_high_n_i,
  input  wire logic        io_read_strobe_n_i,
  input  wire logic        io_write_strobe_n_i,
  input  wire logic [15:0] data_i,
  output logic [15:0]      data_o,
  output logic             data_oe_o,
  output logic             io_ready_o,
  output logic             interrupt_request_n_o,
  // Configuration, same clock.
  input  wire logic [1:0]  map_select_i,
  input  wire logic        direct_disk_mode_i,
  input  wire logic        level_irq_mode_i,
  // Command engine status and events, same clock.
  input  wire logic [7:0]  status_i,
  input  wire logic        irq_set_i,
  input  wire logic        err_clear_i,
  input  wire logic        bad_block_evt_i,
  input  wire logic        uncorrectable_evt_i,
  input  wire logic        sector_missing_evt_i,
  input  wire logic        command_aborted_evt_i,
  input  wire logic        general_error_evt_i,
  input  wire logic        sectors_left_we_i,
  input  wire logic [7:0]  sectors_left_i,
  // Command parameters toward the command engine.
  output logic [7:0]       feature_o,
  output logic [7:0]       sector_count_o,
  output logic [8:0]       transfer_sectors_o,
  output logic [7:0]       start_sector_o,
  output logic [15:0]      start_cylinder_o,
  output logic [7:0]       drive_head_o,
  output logic [7:0]       device_control_o,
  output logic [7:0]       command_o,
  output logic             command_we_o,
  // Sector data toward the flash side.
  output logic             wr_data_valid_o,
  output logic [15:0]      wr_data_o,
  input  wire logic        wr_data_ready_i,
  // Sector data from the flash side.
  input  wire logic        rd_data_valid_i,
  input  wire logic [15:0] rd_data_i,
  output logic             rd_data_ready_o
);
  typedef struct packed {
    logic [10:0] addr;
    logic        regn;
    logic        ce1n;
    logic        ce2n;
    logic        rdn;
    logic        wrn;
    logic [15:0] data;
  } atf_pins_t;

  typedef struct packed {
    atf_pins_t          s1;
    atf_pins_t          s2;
    logic               rdn_prev;
    logic               wrn_prev;
    atf_pkg::atf_state_t state;
    logic [15:0]        dout;
    logic               oe;
    logic               iordy;
    logic               irq_n;
    logic [7:0]         err;
    logic [7:0]         feature;
    logic [7:0]         scount;
    logic [7:0]         snum;
    logic [7:0]         cyl_lo;
    logic [7:0]         cyl_hi;
    logic [7:0]         drv_head;
    logic [7:0]         dev_ctrl;
    logic [7:0]         cmd;
    logic               cmd_we;
    logic [7:0]         byte_lo;
    logic               wr_phase;
    logic               rd_phase;
    logic               push_valid;
    logic [15:0]        push_data;
    logic [15:0]        rd_word;
    logic               rd_full;
    logic               rd_take;
    logic               rd_ready;
  } atf_st_t;

  atf_st_t          st_q;
  atf_st_t          st_d;
  atf_pins_t        pins_now;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [15:0]      fifo_out_data;
  atf_pkg::atf_sel_t sel;
  logic [2:0]       ofs;
  logic             word_acc;
  logic             rd_fall;
  logic             rd_rise;
  logic             wr_rise;
  logic [7:0]       rd_byte;

  // Register group selected in the active map.
  function automatic atf_pkg::atf_sel_t decode_sel(
    input logic [10:0] a, input logic regn, input logic ce1n, input logic ce2n,
    input logic [1:0] map, input logic direct);
    logic [5:0] hi;
    logic       alt_ofs;
    logic [5:0] tbase;
    logic [5:0] abase;
    hi      = a[atf_pkg::A_HI_MSB:atf_pkg::A_HI_LSB];
    alt_ofs = (a[2:0] == atf_pkg::OFS_ALT_CTRL) || (a[2:0] == atf_pkg::OFS_DRV_ADDR);
    tbase   = (map == atf_pkg::MAP_PRIMARY) ? atf_pkg::PRI_TASK_BASE : atf_pkg::SEC_TASK_BASE;
    abase   = (map == atf_pkg::MAP_PRIMARY) ? atf_pkg::PRI_ALT_BASE : atf_pkg::SEC_ALT_BASE;
    decode_sel = atf_pkg::SEL_NONE;
    if (direct) begin
      if (ce2n && !ce1n) begin
        decode_sel = atf_pkg::SEL_TASK; // RL3
      end else if (!ce2n && ce1n && alt_ofs) begin
        decode_sel = (a[2:0] == atf_pkg::OFS_ALT_CTRL) ? atf_pkg::SEL_ALT
                                                       : atf_pkg::SEL_DADR; // RL3
      end
    end else if (!regn && (map == atf_pkg::MAP_PRIMARY || map == atf_pkg::MAP_SECONDARY)
                 && !(ce1n && ce2n) && !a[atf_pkg::A3_BIT]) begin
      if (hi == tbase) begin
        decode_sel = atf_pkg::SEL_TASK; // RL1 RL2
      end else if (hi == abase && alt_ofs) begin
        decode_sel = (a[2:0] == atf_pkg::OFS_ALT_CTRL) ? atf_pkg::SEL_ALT
                                                       : atf_pkg::SEL_DADR; // RL1 RL2
      end
    end
  endfunction

  assign pins_now = '{addr: addr_i, regn: attr_select_n_i, ce1n: chip_select_low_n_i,
                      ce2n: chip_select_high_n_i, rdn: io_read_strobe_n_i,
                      wrn: io_write_strobe_n_i, data: data_i};

  atf_fifo #(
    .WIDTH (atf_pkg::DATA_W),
    .DEPTH (atf_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .in_valid_i  (st_q.push_valid),
    .in_data_i   (st_q.push_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (wr_data_ready_i)
  );

  always_comb begin
    st_d     = st_q;
    st_d.s1  = pins_now;
    st_d.s2  = st_q.s1;
    st_d.rdn_prev = st_q.s2.rdn;
    st_d.wrn_prev = st_q.s2.wrn;
    st_d.cmd_we   = 1'b0;
    sel      = decode_sel(st_q.s2.addr, st_q.s2.regn, st_q.s2.ce1n, st_q.s2.ce2n,
                          map_select_i, direct_disk_mode_i);
    ofs      = st_q.s2.addr[2:0];
    word_acc = !st_q.s2.ce1n && !st_q.s2.ce2n;
    rd_fall  = st_q.rdn_prev && !st_q.s2.rdn;
    rd_rise  = !st_q.rdn_prev && st_q.s2.rdn;
    wr_rise  = !st_q.wrn_prev && st_q.s2.wrn;
    rd_byte  = st_q.rd_phase ? st_q.rd_word[15:8] : st_q.rd_word[7:0];
    if (st_q.push_valid && fifo_in_ready) begin
      st_d.push_valid = 1'b0;
    end
    if (rd_data_valid_i && st_q.rd_ready) begin
      st_d.rd_word = rd_data_i;
      st_d.rd_full = 1'b1;
    end
    // A new event wins over a clear.
    if (err_clear_i) begin
      st_d.err = atf_pkg::RST_BYTE;
    end
    if (bad_block_evt_i) begin
      st_d.err[atf_pkg::ERR_BAD_BLOCK] = 1'b1; // RL7
    end
    if (uncorrectable_evt_i) begin
      st_d.err[atf_pkg::ERR_UNCORR] = 1'b1; // RL9
    end
    if (sector_missing_evt_i) begin
      st_d.err[atf_pkg::ERR_MISSING] = 1'b1; // RL10
    end
    if (command_aborted_evt_i) begin
      st_d.err[atf_pkg::ERR_ABORTED] = 1'b1; // RL8
    end
    if (general_error_evt_i) begin
      st_d.err[atf_pkg::ERR_GENERAL] = 1'b1; // RL7
    end
    if (sectors_left_we_i) begin
      st_d.scount = sectors_left_i; // RL13
    end
    case (st_q.state)
      atf_pkg::ST_IDLE: begin
        if (rd_fall && sel != atf_pkg::SEL_NONE) begin
          st_d.state = atf_pkg::ST_READ;
          st_d.oe    = 1'b1;
          st_d.dout  = atf_pkg::RST_WORD;
          if (sel == atf_pkg::SEL_TASK) begin
            case (ofs)
              atf_pkg::OFS_DATA: begin
                st_d.dout = word_acc ? st_q.rd_word : {8'h00, rd_byte}; // RL4 RL5
              end
              atf_pkg::OFS_ERR_FEAT: st_d.dout[7:0] = st_q.err; // RL6 RL7
              atf_pkg::OFS_SCOUNT:   st_d.dout[7:0] = st_q.scount;
              atf_pkg::OFS_SNUM:     st_d.dout[7:0] = st_q.snum;
              atf_pkg::OFS_CYL_LO:   st_d.dout[7:0] = st_q.cyl_lo;
              atf_pkg::OFS_CYL_HI:   st_d.dout[7:0] = st_q.cyl_hi;
              atf_pkg::OFS_DRV_HEAD: st_d.dout[7:0] = st_q.drv_head;
              atf_pkg::OFS_STAT_CMD: begin
                st_d.dout[7:0] = status_i; // RL17
                if (level_irq_mode_i && !direct_disk_mode_i) begin
                  st_d.irq_n = 1'b1; // RL18
                end
              end
              default: st_d.dout = atf_pkg::RST_WORD;
            endcase
          end else if (sel == atf_pkg::SEL_ALT) begin
            st_d.dout[7:0] = status_i; // RL19
          end else begin
            st_d.dout[7:0] = {atf_pkg::DRV_ADDR_TOP, ~st_q.drv_head[3:0],
                              st_q.drv_head[atf_pkg::DH_DRV_BIT],
                              ~st_q.drv_head[atf_pkg::DH_DRV_BIT]};
          end
        end else if (!st_q.s2.wrn && st_q.wrn_prev && sel != atf_pkg::SEL_NONE) begin
          st_d.state = atf_pkg::ST_WRITE;
        end
      end
      atf_pkg::ST_READ: begin
        if (rd_rise) begin
          st_d.state = atf_pkg::ST_IDLE;
          st_d.oe    = 1'b0;
          if (sel == atf_pkg::SEL_TASK && ofs == atf_pkg::OFS_DATA) begin
            if (word_acc || st_q.rd_phase) begin
              st_d.rd_full  = 1'b0; // RL4
              st_d.rd_phase = 1'b0;
            end else begin
              st_d.rd_phase = 1'b1;
            end
          end
        end
      end
      atf_pkg::ST_WRITE: begin
        if (!st_q.push_valid) begin
          st_d.iordy = 1'b1;
        end
        if (wr_rise) begin
          st_d.state = atf_pkg::ST_IDLE;
          if (sel == atf_pkg::SEL_TASK) begin
            case (ofs)
              atf_pkg::OFS_DATA: begin
                if (word_acc) begin
                  st_d.push_valid = 1'b1; // RL4 RL5
                  st_d.push_data  = st_q.s2.data;
                end else if (st_q.wr_phase) begin
                  st_d.push_valid = 1'b1; // RL4
                  st_d.push_data  = {st_q.s2.data[7:0], st_q.byte_lo};
                  st_d.wr_phase   = 1'b0;
                end else begin
                  st_d.byte_lo  = st_q.s2.data[7:0];
                  st_d.wr_phase = 1'b1;
                end
                st_d.iordy = 1'b0;
              end
              atf_pkg::OFS_ERR_FEAT: st_d.feature  = st_q.s2.data[7:0]; // RL11 RL6
              atf_pkg::OFS_SCOUNT:   st_d.scount   = st_q.s2.data[7:0];
              atf_pkg::OFS_SNUM:     st_d.snum     = st_q.s2.data[7:0]; // RL14
              atf_pkg::OFS_CYL_LO:   st_d.cyl_lo   = st_q.s2.data[7:0]; // RL15
              atf_pkg::OFS_CYL_HI:   st_d.cyl_hi   = st_q.s2.data[7:0]; // RL16
              atf_pkg::OFS_DRV_HEAD: st_d.drv_head = st_q.s2.data[7:0];
              atf_pkg::OFS_STAT_CMD: begin
                st_d.cmd    = st_q.s2.data[7:0];
                st_d.cmd_we = 1'b1;
              end
              default: st_d.cmd_we = 1'b0;
            endcase
          end else if (sel == atf_pkg::SEL_ALT) begin
            st_d.dev_ctrl = st_q.s2.data[7:0];
          end
          // The drive address location takes no write.
        end
      end
      default: begin
        st_d.state = atf_pkg::ST_IDLE; // RL20
        st_d.oe    = 1'b0;
      end
    endcase
    // Set wins over a status read.
    if (irq_set_i) begin
      st_d.irq_n = 1'b0;
    end
    // Wait while a word is not yet in the FIFO.
    if (st_d.push_valid && st_q.state == atf_pkg::ST_WRITE && !wr_rise) begin
      st_d.iordy = 1'b0;
    end else if (!st_d.push_valid) begin
      st_d.iordy = 1'b1;
    end
    st_d.rd_ready = !st_d.rd_full && !(rd_data_valid_i && st_q.rd_ready);
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q          <= '0;
      st_q.s1.rdn   <= 1'b1;
      st_q.s1.wrn   <= 1'b1;
      st_q.s2.rdn   <= 1'b1;
      st_q.s2.wrn   <= 1'b1;
      st_q.rdn_prev <= 1'b1;
      st_q.wrn_prev <= 1'b1;
      st_q.state    <= atf_pkg::ST_IDLE;
      st_q.iordy    <= 1'b1;
      st_q.irq_n    <= 1'b1;
      st_q.drv_head <= atf_pkg::RST_DRV_HEAD;
    end else begin
      st_q <= st_d;
    end
  end

  assign data_o                = st_q.dout;
  assign data_oe_o             = st_q.oe; // RL20
  assign io_ready_o            = st_q.iordy;
  assign interrupt_request_n_o = st_q.irq_n;
  assign feature_o             = st_q.feature;
  assign sector_count_o        = st_q.scount;
  assign start_sector_o        = st_q.snum;
  assign start_cylinder_o      = {st_q.cyl_hi, st_q.cyl_lo};
  assign drive_head_o          = st_q.drv_head;
  assign device_control_o      = st_q.dev_ctrl;
  assign command_o             = st_q.cmd;
  assign command_we_o          = st_q.cmd_we;
  assign rd_data_ready_o       = st_q.rd_ready;
  assign wr_data_valid_o       = fifo_out_valid;
  assign wr_data_o             = fifo_out_data;

  logic [8:0] run_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      run_q <= atf_pkg::FULL_SECTOR_RUN;
    end else begin
      run_q <= (st_d.scount == atf_pkg::RST_BYTE) ? atf_pkg::FULL_SECTOR_RUN
                                                  : {1'b0, st_d.scount}; // RL12
    end
  end
  assign transfer_sectors_o = run_q;
endmodule
`default_nettype wire

//--- dv/atf_host_port_properties.sv
// Concurrent checks on the task file host port, bound to every instance.
// Assumes the host holds address and selects steady through each strobe.
`timescale 1ns/10ps
`default_nettype none
module atf_host_port_properties (
  // Clock and reset.
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // Host pins.
  input wire logic [10:0] addr_i,
  input wire logic        attr_select_n_i,
  input wire logic        chip_select_low_n_i,
  input wire logic        io_read_strobe_n_i,
  input wire logic        io_write_strobe_n_i,
  input wire logic        data_oe_o,
  input wire logic        interrupt_request_n_o,
  // Configuration and engine side.
  input wire logic [1:0]  map_select_i,
  input wire logic        direct_disk_mode_i,
  input wire logic        irq_set_i,
  input wire logic        sectors_left_we_i,
  input wire logic [7:0]  sectors_left_i,
  input wire logic [7:0]  sector_count_o,
  input wire logic [8:0]  transfer_sectors_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic io_ok;
  assign io_ok = !direct_disk_mode_i && !attr_select_n_i && !chip_select_low_n_i && !addr_i[3];
  idle_quiet_a: assert property (io_read_strobe_n_i [*5] |-> !data_oe_o)
    else $error("idle drive");
  map_quiet_a: assert property ((!map_select_i[1] && !direct_disk_mode_i) [*8] |-> !data_oe_o)
    else $error("memory map drive");
  attr_quiet_a: assert property ((attr_select_n_i && !direct_disk_mode_i) [*8] |-> !data_oe_o)
    else $error("attribute drive");
  pri_answer_a: assert property ($fell(io_read_strobe_n_i) && io_ok
    && map_select_i == atf_pkg::MAP_PRIMARY && addr_i[9:4] == atf_pkg::PRI_TASK_BASE
    |-> ##[2:5] data_oe_o) else $error("primary read not answered");
  sec_answer_a: assert property ($fell(io_read_strobe_n_i) && io_ok
    && map_select_i == atf_pkg::MAP_SECONDARY && addr_i[9:4] == atf_pkg::SEC_TASK_BASE
    |-> ##[2:5] data_oe_o) else $error("secondary read not answered");
  full_run_a: assert property (transfer_sectors_o == (sector_count_o == 8'h00 ?
    atf_pkg::FULL_SECTOR_RUN : {1'b0, sector_count_o})) else $error("bad sector run");
  left_load_a: assert property (sectors_left_we_i && io_write_strobe_n_i
    && $past(io_write_strobe_n_i, 6) |=> sector_count_o == $past(sectors_left_i))
    else $error("count not loaded");
  irq_raise_a: assert property (irq_set_i |=> !interrupt_request_n_o)
    else $error("no interrupt");
endmodule
bind atf_host_port atf_host_port_properties u_props (.*);
`default_nettype wire

//--- dv/atf_host_model.sv
// Host bus controller model issuing I/O read and write cycles.
// Assumes the bench calls cycle from one process at a time.
`timescale 1ns/10ps
`default_nettype none
module atf_host_model (
  // Clock and wait input.
  input wire logic   clk_sys_i,
  input wire logic   io_ready_i,
  // Host pins.
  output logic [10:0] addr_o,
  output logic [1:0]  ce_n_o,
  output logic        rd_n_o,
  output logic        wr_n_o,
  output logic [15:0] data_o
);
  initial begin
    addr_o = 11'h000;
    ce_n_o = 2'h3;
    {rd_n_o, wr_n_o} = 2'h3;
    data_o = 16'h0000;
  end
  // A write is held during wait so no word is lost.
  task automatic cycle(input logic wr, input logic [10:0] a, input logic [1:0] ce,
                       input logic [15:0] d, output logic ok);
    int n;
    @(negedge clk_sys_i);
    addr_o = a;
    ce_n_o = ce;
    data_o = wr ? d : ~data_o;
    if (wr) wr_n_o = 1'b0;
    else rd_n_o = 1'b0;
    repeat (8) @(negedge clk_sys_i);
    for (n = 0; wr && io_ready_i !== 1'b1 && n < 2000; n++) @(negedge clk_sys_i);
    ok = n < 2000;
    {rd_n_o, wr_n_o} = 2'h3;
    repeat (8) @(negedge clk_sys_i);
    ce_n_o = 2'h3;
    data_o = ~data_o;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench for the task file host port.
// Assumes a 200 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys_i = 0, rst_i = 1, attr_n = 0, direct = 0, irq_set = 0, err_clr = 0;
  logic left_we = 0, wr_rdy = 0, rdy_en = 0, oe, oe_d = 0, io_rdy, irq_n, wvld, seen_wait = 0, ok;
  logic [1:0]  map = atf_pkg::MAP_PRIMARY, ce;
  logic [4:0]  evt = 5'h00;
  logic [7:0]  stat = 8'h50, left = 8'h00, feat, cnt, ssec, v, ebit [5];
  logic [10:0] addr;
  logic [15:0] dout, din, wdat, rword = 16'hA5C3, cyl, base;
  logic [31:0] seed = 32'hA554_CA4A;
  logic        rd, wr;
  logic [15:0] rd_q [$], wr_q [$];
  int          miscompares = 0, check_count = 0, i, m;
  always #2.5 clk_sys_i = ~clk_sys_i;
  atf_host_model host (.clk_sys_i, .io_ready_i(io_rdy), .addr_o(addr), .ce_n_o(ce),
    .rd_n_o(rd), .wr_n_o(wr), .data_o(din));
  atf_host_port dut (.clk_sys_i, .rst_i, .addr_i(addr), .attr_select_n_i(attr_n),
    .chip_select_low_n_i(ce[0]), .chip_select_high_n_i(ce[1]), .io_read_strobe_n_i(rd),
    .io_write_strobe_n_i(wr), .data_i(din), .data_o(dout), .data_oe_o(oe),
    .io_ready_o(io_rdy), .interrupt_request_n_o(irq_n), .map_select_i(map),
    .direct_disk_mode_i(direct), .level_irq_mode_i(1'b1), .status_i(stat),
    .irq_set_i(irq_set), .err_clear_i(err_clr), .bad_block_evt_i(evt[4]),
    .uncorrectable_evt_i(evt[3]), .sector_missing_evt_i(evt[2]),
    .command_aborted_evt_i(evt[1]), .general_error_evt_i(evt[0]),
    .sectors_left_we_i(left_we), .sectors_left_i(left), .feature_o(feat),
    .sector_count_o(cnt), .transfer_sectors_o(), .start_sector_o(ssec),
    .start_cylinder_o(cyl), .drive_head_o(), .device_control_o(), .command_o(),
    .command_we_o(), .wr_data_valid_o(wvld), .wr_data_o(wdat), .wr_data_ready_i(wr_rdy),
    .rd_data_valid_i(1'b1), .rd_data_i(rword), .rd_data_ready_o());
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic io(input logic w, input logic [10:0] a, input logic [1:0] c,
                    input logic [15:0] d, input logic note);
    if (note) begin
      if (w) wr_q.push_back(d);
      else rd_q.push_back(d);
    end
    host.cycle(w, a, c, d, ok);
    if (!ok) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys_i) s = 1'b1;
    @(negedge clk_sys_i) s = 1'b0;
  endtask
  // An unnoted bus drive is a fault.
  always @(negedge clk_sys_i) begin
    if (oe === 1'b1 && oe_d !== 1'b1) begin
      if (rd_q.size() > 0) chk("read data", rd_q.pop_front(), dout);
      else chk("read drive", 16'h0000, 16'h0001);
    end
    oe_d = oe;
    if (io_rdy === 1'b0) seen_wait = 1'b1;
    seed = xs(seed);
    wr_rdy <= rdy_en & seed[3];
  end
  always @(posedge clk_sys_i) begin
    if (wvld === 1'b1 && wr_rdy) chk("buffer word", wr_q.pop_front(), wdat);
    rword <= rword + 16'h0101;
  end
  initial begin
    ebit = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h01};
    repeat (8) @(negedge clk_sys_i);
    rst_i = 0;
    repeat (4) @(negedge clk_sys_i);
    for (m = 0; m < 3; m++) begin
      map = m == 1 ? atf_pkg::MAP_SECONDARY : atf_pkg::MAP_PRIMARY;
      direct = m == 2;
      base = {5'h00, m == 1 ? atf_pkg::SEC_TASK_BASE : atf_pkg::PRI_TASK_BASE, 4'h0};
      for (i = 2; i < 5; i++) begin
        v = (m == 0 && i == 2) ? 8'h00 : seed[7:0];
        io(1, base[10:0] | i, 2'h2, {8'h00, v}, 0);
        io(0, base[10:0] | i, 2'h2, {8'h00, v}, 1);
        chk("task register", {8'h00, v}, i == 2 ? cnt : i == 3 ? ssec : cyl[7:0]);
      end
      $display("test map %0d done", m);
    end
    direct = 0;
    map = atf_pkg::MAP_PRIMARY;
    io(0, 11'h1F7, 2'h2, {8'h00, stat}, 1);
    for (i = 0; i < 5; i++) begin
      @(negedge clk_sys_i) evt = 5'h10 >> i;
      @(negedge clk_sys_i) evt = 5'h00;
      io(0, 11'h1F1, 2'h2, {8'h00, ebit[i]}, 1);
      pulse(err_clr);
    end
    io(1, 11'h1F1, 2'h2, 16'h00FF, 0);
    chk("feature", 16'h00FF, {8'h00, feat});
    io(0, 11'h1F1, 2'h2, 16'h0000, 1);
    left = 8'h2A;
    pulse(left_we);
    io(0, 11'h1F2, 2'h2, 16'h002A, 1);
    pulse(irq_set);
    io(0, 11'h3F6, 2'h2, {8'h00, stat}, 1);
    chk("irq after alt", 16'h0000, {15'h0000, irq_n});
    io(0, 11'h1F7, 2'h2, {8'h00, stat}, 1);
    chk("irq after status", 16'h0001, {15'h0000, irq_n});
    io(0, 11'h1F9, 2'h2, 16'h0000, 0);
    attr_n = 1;
    io(0, 11'h1F2, 2'h2, 16'h0000, 0);
    attr_n = 0;
    map = atf_pkg::MAP_MEMORY;
    io(0, 11'h1F2, 2'h2, 16'h0000, 0);
    map = atf_pkg::MAP_PRIMARY;
    $display("test registers done");
    fork
      begin
        repeat (700) @(negedge clk_sys_i);
        rdy_en = 1;
      end
    join_none
    for (i = 0; i < 20; i++) io(1, 11'h1F0, 2'h0, seed[15:0], 1);
    for (i = 0; i < 2000 && wr_q.size() > 0; i++) @(negedge clk_sys_i);
    chk("buffer drained", 16'h0000, wr_q.size());
    chk("write wait seen", 16'h0001, {15'h0000, seen_wait});
    $display("test buffer done");
    report_and_stop();
  end
endmodule
`default_nettype wire
